//--- core/tsc_pkg.sv
// package: register map, field layouts and reset values of the thermal sensor control block
package tsc_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFF_START_TASK = 12'h000;
  localparam logic [11:0] OFF_STOP_TASK = 12'h004;
  localparam logic [11:0] OFF_RESULT_READY_EVENT = 12'h100;
  localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFF_THERMAL_RESULT = 12'h508;

  // ****************************************
  // compensation coefficients: six slopes, six intercepts, five end points
  // ****************************************
  localparam int NUM_COEF = 17;
  localparam int IDX_SLOPE_1 = 0;
  localparam int IDX_INTERCEPT_1 = 6;
  localparam int IDX_ENDPOINT_1 = 12;
  localparam logic [11:0] COEF_OFF [NUM_COEF] = '{
    12'h520, 12'h524, 12'h528, 12'h52C, 12'h530, 12'h534,
    12'h540, 12'h544, 12'h548, 12'h54C, 12'h550, 12'h554,
    12'h560, 12'h564, 12'h568, 12'h56C, 12'h570};
  localparam logic [31:0] SLOPE_MASK = 32'h0000_0FFF;
  localparam logic [31:0] INTERCEPT_MASK = 32'h0000_3FFF;
  localparam logic [31:0] ENDPOINT_MASK = 32'h0000_00FF;
  localparam logic [31:0] COEF_MASK [NUM_COEF] = '{
    SLOPE_MASK, SLOPE_MASK, SLOPE_MASK, SLOPE_MASK, SLOPE_MASK, SLOPE_MASK,
    INTERCEPT_MASK, INTERCEPT_MASK, INTERCEPT_MASK, INTERCEPT_MASK, INTERCEPT_MASK,
    INTERCEPT_MASK,
    ENDPOINT_MASK, ENDPOINT_MASK, ENDPOINT_MASK, ENDPOINT_MASK, ENDPOINT_MASK};
  localparam logic [31:0] COEF_RST [NUM_COEF] = '{
    32'h0000_0326, 32'h0000_0348, 32'h0000_03AA, 32'h0000_040E, 32'h0000_04BD,
    32'h0000_05A3,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // ****************************************
  // field positions and misc
  // ****************************************
  localparam int EVENT_BIT = 0;
  localparam int IRQ_BIT = 0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int ADDR_W = 12;

  typedef enum logic [0:0] {TSC_IDLE, TSC_MEAS} tsc_state_t;

endpackage

//--- core/tsc_top.sv
// thermal sensor control: AHB-Lite register slave, one-shot measurement sequencer
// Functional notes
// R1 - a measurement begins only on a software write to the start task register
// R2 - on completion the event rises and the result updates together
// R3 - result register reads return the latest completed measurement
// R4 - result is two's complement, one count is a quarter degree
// R5 - front end power enable drops as soon as measurement completes
// R6 - one measurement per start; never restarts by itself
// R7 - result resolution is a quarter degree per count
// R8 - completion indication readable at its own event register, offset 0x100
// R9 - six slope coefficients held at 0x520 to 0x534
// R10 - six intercept coefficients held at 0x540 to 0x554
// R11 - five segment end points held at 0x560 to 0x570
// R12 - clock controller must select crystal as high frequency source during measurement; this block has no clock source request output
// R13 - stop task aborts measurement, powers down, keeps result and event
// R14 - interrupt enable set by set register, cleared by clear register, zeros ignored
//
// Chosen here: register access over AHB-Lite.
module tsc_top #(
  parameter int TEMP_W = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic afe_power_en,
  input wire logic afe_done,
  input wire logic [TEMP_W-1:0] afe_data,
  output logic irq
);

  if (TEMP_W < 2 || TEMP_W > 32) begin : g_bad_temp_w
    $error("tsc_top: TEMP_W must lie in 2..32");
  end

  // ****************************************
  // bus address phase capture
  // ****************************************
  logic wr_pend;
  logic rd_pend;
  logic [tsc_pkg::ADDR_W-1:0] acc_addr;
  logic acc_take;

  assign acc_take = hsel && hready && (htrans == tsc_pkg::HTRANS_NONSEQ) &&
                    (hsize == tsc_pkg::HSIZE_WORD) && (haddr[1:0] == 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_addr <= '0;
    end else begin
      wr_pend <= acc_take && hwrite;
      rd_pend <= acc_take && !hwrite;
      if (acc_take) begin
        acc_addr <= haddr[tsc_pkg::ADDR_W-1:0];
      end
    end
  end

  // reads take one wait state so hrdata can come from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !(acc_take && !hwrite);
      hresp <= 1'b0;
    end
  end

  logic start_wr;
  logic stop_wr;
  logic event_wr;
  logic inten_set_wr;
  logic inten_clr_wr;

  assign start_wr = wr_pend && (acc_addr == tsc_pkg::OFF_START_TASK);
  assign stop_wr = wr_pend && (acc_addr == tsc_pkg::OFF_STOP_TASK);
  assign event_wr = wr_pend && (acc_addr == tsc_pkg::OFF_RESULT_READY_EVENT);
  assign inten_set_wr = wr_pend && (acc_addr == tsc_pkg::OFF_IRQ_ENABLE_SET);
  assign inten_clr_wr = wr_pend && (acc_addr == tsc_pkg::OFF_IRQ_ENABLE_CLEAR);

  // ****************************************
  // front end input synchronisers
  // ****************************************
  logic done_s1;
  logic done_s2;
  logic done_s3;
  logic [TEMP_W-1:0] data_s1;
  logic [TEMP_W-1:0] data_s2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      done_s1 <= afe_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      data_s1 <= afe_data;
      data_s2 <= data_s1;
    end
  end

  // ****************************************
  // measurement sequencer
  // ****************************************
  tsc_pkg::tsc_state_t state;
  logic meas_done;
  logic [31:0] next_result;

  assign meas_done = (state == tsc_pkg::TSC_MEAS) && done_s2 && !done_s3 && !stop_wr;
  assign next_result = 32'($signed(data_s2)); // R4 R7

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= tsc_pkg::TSC_IDLE;
      afe_power_en <= 1'b0;
    end else begin
      unique case (state)
        tsc_pkg::TSC_IDLE: begin
          if (start_wr) begin // R1 R6
            state <= tsc_pkg::TSC_MEAS;
            afe_power_en <= 1'b1;
          end
        end
        tsc_pkg::TSC_MEAS: begin
          if (stop_wr || meas_done) begin // R5 R13
            state <= tsc_pkg::TSC_IDLE;
            afe_power_en <= 1'b0;
          end
        end
      endcase
    end
  end

  logic [31:0] thermal_result;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_result <= '0;
    end else if (meas_done) begin // R2 R3
      thermal_result <= next_result;
    end
  end

  // ****************************************
  // event and interrupt
  // ****************************************
  logic result_ready_event;
  logic irq_enable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_ready_event <= 1'b0;
    end else if (meas_done) begin // R2 R8
      result_ready_event <= 1'b1;
    end else if (event_wr && hwdata[tsc_pkg::EVENT_BIT]) begin
      result_ready_event <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable <= 1'b0;
    end else if (inten_set_wr && hwdata[tsc_pkg::IRQ_BIT]) begin // R14
      irq_enable <= 1'b1;
    end else if (inten_clr_wr && hwdata[tsc_pkg::IRQ_BIT]) begin // R14
      irq_enable <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= result_ready_event && irq_enable;
    end
  end

  // ****************************************
  // compensation coefficients
  // ****************************************
  logic [31:0] coef [tsc_pkg::NUM_COEF];

  for (genvar i = 0; i < tsc_pkg::NUM_COEF; i++) begin : g_coef
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        coef[i] <= tsc_pkg::COEF_RST[i];
      end else if (wr_pend && acc_addr == tsc_pkg::COEF_OFF[i]) begin // R9 R10 R11
        coef[i] <= hwdata & tsc_pkg::COEF_MASK[i];
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (acc_addr)
      tsc_pkg::OFF_RESULT_READY_EVENT: rd_mux = {31'h0, result_ready_event}; // R8
      tsc_pkg::OFF_IRQ_ENABLE_SET: rd_mux = {31'h0, irq_enable};
      tsc_pkg::OFF_IRQ_ENABLE_CLEAR: rd_mux = {31'h0, irq_enable};
      tsc_pkg::OFF_THERMAL_RESULT: rd_mux = thermal_result; // R3
      default: begin
        for (int k = 0; k < tsc_pkg::NUM_COEF; k++) begin
          if (acc_addr == tsc_pkg::COEF_OFF[k]) begin
            rd_mux = coef[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_pend) begin
      hrdata <= rd_mux;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_start_idle;
    start_wr && state == tsc_pkg::TSC_IDLE;
  endsequence

  sequence s_finish;
    result_ready_event && !afe_power_en;
  endsequence

  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_enable_on;
    irq_enable ##1 (irq == $past(result_ready_event));
  endsequence

  sequence s_enable_off;
    !irq_enable ##1 !irq;
  endsequence

  // ****************************************
  // bus protocol checks
  // ****************************************
  a_read_wait: assert property (acc_take && !hwrite |=> s_rd_wait)
    else $error("read did not insert one wait state");

  a_write_nowait: assert property (acc_take && hwrite |=> hreadyout)
    else $error("write data phase was stretched");

  a_resp_okay: assert property (!hresp)
    else $error("slave answered with an error response");

  a_rdata_holds: assert property (!rd_pend |=> $stable(hrdata))
    else $error("read data changed outside a read");

  a_event_read: assert property (rd_pend && acc_addr == tsc_pkg::OFF_RESULT_READY_EVENT // R8
                                 |=> hrdata == {31'h0, $past(result_ready_event)} && hreadyout)
    else $error("event register read wrong");

  a_result_read: assert property (rd_pend && acc_addr == tsc_pkg::OFF_THERMAL_RESULT // R3
                                  |=> hrdata == $past(thermal_result))
    else $error("result register read wrong");

  // ****************************************
  // sequencer checks
  // ****************************************
  a_start_powers: assert property (s_start_idle |=> afe_power_en) // R1
    else $error("start write did not power the front end");

  a_done_event: assert property (meas_done |=> s_finish ##0 // R2
                                 (thermal_result == $past(next_result)))
    else $error("completion did not latch result with event");

  a_done_power_off: assert property (meas_done |=> !afe_power_en ##1 // R5
                                     (!afe_power_en || $past(start_wr)))
    else $error("front end stayed powered after completion");

  a_no_self_start: assert property (!afe_power_en && !start_wr |=> !afe_power_en) // R6
    else $error("measurement began without a start write");

  a_meas_holds: assert property (state == tsc_pkg::TSC_MEAS && !stop_wr && !meas_done // R6
                                 |=> afe_power_en)
    else $error("measurement ended without completion or stop");

  a_result_holds: assert property (!meas_done |=> $stable(thermal_result)) // R3
    else $error("result changed without a completed measurement");

  a_result_sign: assert property (thermal_result[31:TEMP_W-1] == '0 || // R4 R7
                                  thermal_result[31:TEMP_W-1] == '1)
    else $error("result is not a sign extended count");

  a_stop_abort: assert property (stop_wr |=> !afe_power_en && // R13
                                 $stable(thermal_result) && $stable(result_ready_event))
    else $error("stop write did not abort cleanly");

  // ****************************************
  // event and interrupt checks
  // ****************************************
  a_event_only_done: assert property (!result_ready_event && !meas_done // R2
                                      |=> !result_ready_event)
    else $error("event rose without a completed measurement");

  a_event_sticky: assert property (result_ready_event && !event_wr |=> result_ready_event) // R8
    else $error("event dropped without a clearing write");

  a_event_clear: assert property (event_wr && hwdata[tsc_pkg::EVENT_BIT] && !meas_done // R8
                                  |=> !result_ready_event)
    else $error("writing one did not clear the event");

  a_irq_enable: assert property (inten_set_wr && hwdata[tsc_pkg::IRQ_BIT] |=> s_enable_on) // R14
    else $error("interrupt enable set failed");

  a_irq_disable: assert property (inten_clr_wr && hwdata[tsc_pkg::IRQ_BIT] // R14
                                  |=> s_enable_off)
    else $error("interrupt enable clear failed");

  a_set_zero: assert property (inten_set_wr && !hwdata[tsc_pkg::IRQ_BIT] // R14
                               |=> $stable(irq_enable))
    else $error("writing zero to the set register changed the enable");

  a_clr_zero: assert property (inten_clr_wr && !hwdata[tsc_pkg::IRQ_BIT] // R14
                               |=> $stable(irq_enable))
    else $error("writing zero to the clear register changed the enable");

  a_irq_masked: assert property (!irq_enable || !result_ready_event |=> !irq) // R14
    else $error("interrupt raised while masked or without an event");

  // ****************************************
  // coefficient register checks
  // ****************************************
  a_slope_write: assert property (wr_pend && // R9
    acc_addr == tsc_pkg::COEF_OFF[tsc_pkg::IDX_SLOPE_1] |=>
    coef[tsc_pkg::IDX_SLOPE_1] == ($past(hwdata) & tsc_pkg::SLOPE_MASK))
    else $error("slope write not stored");

  a_icpt_write: assert property (wr_pend && // R10
    acc_addr == tsc_pkg::COEF_OFF[tsc_pkg::IDX_INTERCEPT_1] |=>
    coef[tsc_pkg::IDX_INTERCEPT_1] == ($past(hwdata) & tsc_pkg::INTERCEPT_MASK))
    else $error("intercept write not stored");

  a_endp_write: assert property (wr_pend && // R11
    acc_addr == tsc_pkg::COEF_OFF[tsc_pkg::IDX_ENDPOINT_1] |=>
    coef[tsc_pkg::IDX_ENDPOINT_1] == ($past(hwdata) & tsc_pkg::ENDPOINT_MASK))
    else $error("end point write not stored");

  for (genvar j = 0; j < tsc_pkg::NUM_COEF; j++) begin : g_coef_chk
    a_coef_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R9 R10 R11
      !(wr_pend && acc_addr == tsc_pkg::COEF_OFF[j]) |=> $stable(coef[j]))
      else $error("coefficient changed without a write to it");

    a_coef_read: assert property (@(posedge hclk) disable iff (!hresetn) // R9 R10 R11
      rd_pend && acc_addr == tsc_pkg::COEF_OFF[j] |=> hrdata == $past(coef[j]))
      else $error("coefficient read wrong");
  end

endmodule

//--- sim/tsc_afe_model.sv
// analog temperature front end model driven by the power enable
module tsc_afe_model #(
  parameter int TEMP_W = 10
) (
  input wire logic hclk,
  input wire logic afe_power_en,
  input wire logic [7:0] delay,
  input wire logic [TEMP_W-1:0] value,
  output logic afe_done,
  output logic [TEMP_W-1:0] afe_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cnt;
  initial begin
    afe_done = 1'b0;
    afe_data = '0;
    cnt = '0;
  end
  // ****************************************
  // conversion
  // ****************************************
  always @(posedge hclk) begin
    if (afe_power_en !== 1'b1) begin
      // unpowered data output is not held: it toggles every cycle; done is held low
      cnt <= '0;
      afe_done <= 1'b0;
      afe_data <= ~afe_data;
    end else begin
      cnt <= cnt + 9'h001;
      if (cnt == {1'b0, delay}) afe_data <= value;
      if (cnt == {1'b0, delay} + 9'h001) afe_done <= 1'b1;
    end
  end
endmodule

//--- sim/tsc_top_tb_top.sv
// self-checking bench of the thermal sensor control block
module tsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TW = 10;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, afe_power_en, afe_done, irq;
  logic [31:0] haddr, hwdata, hrdata, rd, lf;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [TW-1:0] afe_data, t_val;
  logic [7:0] t_dly;
  int errors, n_tests;
  wire logic hready;
  assign hready = hreadyout;
  tsc_top #(.TEMP_W(TW)) tsc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .afe_power_en(afe_power_en), .afe_done(afe_done), .afe_data(afe_data), .irq(irq));
  tsc_afe_model #(.TEMP_W(TW)) tsc_afe_model_inst (.hclk(hclk), .afe_power_en(afe_power_en),
    .delay(t_dly), .value(t_val), .afe_done(afe_done), .afe_data(afe_data));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] sx(input logic [TW-1:0] v);
    return {{(32-TW){v[TW-1]}}, v};
  endfunction
  task automatic end_of_test();
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single AHB-Lite word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= tsc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= tsc_pkg::HSIZE_WORD;
    i = 0;
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 100);
    rd = hrdata;
    if (i >= 100) errors++;
    cmp({31'h0, hresp}, 32'h0);
  endtask
  task automatic start_meas();
    int i;
    bus(1'b1, tsc_pkg::OFF_START_TASK, lf);
    @(posedge hclk);
    cmp({31'h0, afe_power_en}, 32'h1);
    i = 0;
    while (afe_power_en !== 1'b0 && i < 400) begin @(posedge hclk); i++; end
    repeat (2) @(posedge hclk);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_of_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hsize = '0;
    hwdata = '0;
    t_val = '0;
    t_dly = 8'h04;
    errors = 0;
    n_tests = 0;
    lf = 32'h1895;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < tsc_pkg::NUM_COEF; k++) begin
      bus(1'b0, tsc_pkg::COEF_OFF[k], 32'h0);
      cmp(rd, tsc_pkg::COEF_RST[k]);
      lf = lfsr(lf);
      bus(1'b1, tsc_pkg::COEF_OFF[k], lf);
      bus(1'b0, tsc_pkg::COEF_OFF[k], 32'h0);
      cmp(rd, lf & tsc_pkg::COEF_MASK[k]);
    end
    bus(1'b0, tsc_pkg::OFF_RESULT_READY_EVENT, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b1, 32'h200, 32'hFFFF_FFFF);
    bus(1'b0, 32'h200, 32'h0);
    cmp(rd, 32'h0);
    cmp({31'h0, afe_power_en}, 32'h0);
    bus(1'b1, tsc_pkg::OFF_IRQ_ENABLE_SET, 32'hFFFF_FFFE);
    bus(1'b0, tsc_pkg::OFF_IRQ_ENABLE_SET, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b1, tsc_pkg::OFF_IRQ_ENABLE_SET, 32'h1);
    for (int m = 0; m < 4; m++) begin
      lf = lfsr(lf);
      t_val <= (m == 0) ? 10'h200 : lf[TW-1:0];
      t_dly <= (m == 3) ? 8'h60 : {4'h0, lf[19:16]} + 8'h01;
      start_meas();
      cmp({31'h0, irq}, 32'h1);
      bus(1'b0, tsc_pkg::OFF_THERMAL_RESULT, 32'h0);
      cmp(rd, sx(t_val));
      bus(1'b0, tsc_pkg::OFF_RESULT_READY_EVENT, 32'h0);
      cmp(rd, 32'h1);
      repeat (30) @(posedge hclk);
      cmp({31'h0, afe_power_en}, 32'h0);
      bus(1'b1, tsc_pkg::OFF_RESULT_READY_EVENT, 32'h1);
      repeat (2) @(posedge hclk);
      cmp({31'h0, irq}, 32'h0);
    end
    t_dly <= 8'hC8;
    bus(1'b1, tsc_pkg::OFF_START_TASK, 32'h0);
    repeat (5) @(posedge hclk);
    bus(1'b1, tsc_pkg::OFF_STOP_TASK, 32'h0);
    repeat (300) @(posedge hclk);
    cmp({31'h0, afe_power_en}, 32'h0);
    bus(1'b0, tsc_pkg::OFF_THERMAL_RESULT, 32'h0);
    cmp(rd, sx(t_val));
    bus(1'b0, tsc_pkg::OFF_RESULT_READY_EVENT, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b1, tsc_pkg::OFF_IRQ_ENABLE_CLEAR, 32'h1);
    bus(1'b0, tsc_pkg::OFF_IRQ_ENABLE_CLEAR, 32'h0);
    cmp(rd, 32'h0);
    t_dly <= 8'h03;
    start_meas();
    cmp({31'h0, irq}, 32'h0);
    bus(1'b0, tsc_pkg::OFF_RESULT_READY_EVENT, 32'h0);
    cmp(rd, 32'h1);
    end_of_test();
  end
endmodule
